// ===== verilog/aop_serial_port.sv
// converter serial output port with strap-selected self-clocked, external-clocked and byte modes
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - standby low halts port and floats outputs
// - strap picks self, external or byte mode
// - self mode: 16 periods of 64 clocks
// - select polled per computation period, MSB first
// - after LSB: ready high, data floats
// - select high: stop after bit, resume later
// - unsent word: ready high four clocks, reload
// - self mode: data changes on clock fall
// - external mode: MSB on select fall, shifts
// - external busy: new word discarded
// - external: select high floats, resumes same bit
// - external, select high, unsent: four-clock pulse
// - byte mode: upper byte framed on fall
// - second select low sends lower byte
// - byte mode busy: new word ignored
// - gap between bytes may load new word
// - ready held high during calibration
module aop_serial_port #(
  parameter int SETTLE_CYCLES = aop_pkg::SETTLE_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [aop_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [aop_pkg::DATA_W-1:0] pwdata_in,
  output logic [aop_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // converter core
  input wire logic [aop_pkg::WORD_W-1:0] word_in,
  input wire logic word_valid_in,
  input wire logic cal_busy_in,
  // pins
  input wire logic [1:0] mode_strap_in,
  input wire logic sleep_n_in,
  input wire logic select_n_in,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_out,
  output logic serial_out,
  output logic serial_oe_out,
  output logic word_ready_n_out
);
  logic [aop_pkg::PIN_W-1:0] pin_raw;
  logic [aop_pkg::PIN_W-1:0] sync1_reg;
  logic [aop_pkg::PIN_W-1:0] sync2_reg;
  logic sel_n, sclk_s, awake, sclk_d_reg, sclk_fall;
  logic [1:0] mode;
  logic is_self, is_ext, is_async;
  logic en_reg, rd_hit;
  logic [aop_pkg::DATA_W-1:0] rd_data;
  logic [aop_pkg::PH_W-1:0] ph_reg;
  logic dig_start, per_end;
  logic [aop_pkg::SET_W-1:0] settle_cnt_reg;
  logic settled_reg;
  aop_pkg::aop_tx_type st_reg, st_next;
  logic [4:0] sent_reg, sent_next;
  logic [aop_pkg::SC_W-1:0] sc_reg, sc_next;
  logic [3:0] fb_reg, fb_next;
  logic armed_reg, armed_next;
  logic [2:0] hold_reg;
  logic [aop_pkg::WORD_W-1:0] word_reg, stash_reg;
  logic rdy_n_reg, unsent, busy, drop, take, load_now, pulse_go;
  logic ser_next;
  logic [7:0] cur_byte;

  // pin synchronisers; the first stage feeds only the second
  assign pin_raw = {mode_strap_in, sleep_n_in, sclk_in, select_n_in};
  genvar gi;
  generate
    for (gi = 0; gi < aop_pkg::PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_reg[gi] <= aop_pkg::PIN_RST[gi];
          sync2_reg[gi] <= aop_pkg::PIN_RST[gi];
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  assign sel_n = sync2_reg[0];
  assign sclk_s = sync2_reg[1];
  assign awake = sync2_reg[2];
  assign mode = sync2_reg[4:3];
  assign is_self = mode == aop_pkg::MODE_SELF;
  assign is_ext = mode == aop_pkg::MODE_EXT;
  assign is_async = mode == aop_pkg::MODE_ASYNC;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sclk_d_reg <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
    end
  end
  assign sclk_fall = sclk_d_reg & ~sclk_s;

  // apb: zero wait states, read data captured in the setup cycle
  always_comb begin
    rd_hit = 1'b1;
    rd_data = '0;
    case (paddr_in)
      aop_pkg::REG_CTRL: rd_data = 32'(en_reg);
      aop_pkg::REG_STAT: rd_data = 32'({sent_reg, rdy_n_reg, busy, settled_reg, mode});
      aop_pkg::REG_WORD: rd_data = 32'(word_reg);
      default: rd_hit = 1'b0;
    endcase
  end
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~rd_hit;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prdata_out <= '0;
    end else if (psel_in & ~penable_in) begin
      prdata_out <= rd_data;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      en_reg <= aop_pkg::CTRL_EN_RST;
    end else if (psel_in & penable_in & pwrite_in & (paddr_in == aop_pkg::REG_CTRL)) begin
      en_reg <= pwdata_in[aop_pkg::CTRL_EN_BIT];
    end
  end

  // sampling-interval phase; upper half holds the computation periods
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ph_reg <= '0;
    end else if (!awake) begin
      ph_reg <= '0;
    end else begin
      ph_reg <= ph_reg + 1'b1;
    end
  end
  // poll one clock early so every shift clock of a period stays inside it
  assign dig_start = (ph_reg[aop_pkg::SUB_W-1:0] == '1)
    & (ph_reg[aop_pkg::PH_W-1] ^ (ph_reg[aop_pkg::PH_W-2:aop_pkg::SUB_W] == '1));
  assign per_end = ph_reg[aop_pkg::SUB_W-1:0] == '1;

  // after standby, ready stays high until the filter has settled
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      settle_cnt_reg <= '0;
      settled_reg <= 1'b1;
    end else if (!awake) begin
      settle_cnt_reg <= '0;
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
      if (settle_cnt_reg == aop_pkg::SET_W'(SETTLE_CYCLES - 1)) begin
        settled_reg <= 1'b1;
      end
    end
  end

  // output word handling
  assign unsent = ~rdy_n_reg;
  assign busy = st_reg == aop_pkg::TX_ON;
  assign drop = (is_ext | is_async) & ~sel_n & busy;
  assign take = word_valid_in & awake & ~drop & (hold_reg == '0);
  assign pulse_go = take & unsent;
  assign load_now = (hold_reg == aop_pkg::HOLD_LAST) | (take & ~unsent);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      word_reg <= '0;
      stash_reg <= '0;
      hold_reg <= '0;
    end else begin
      if (pulse_go) begin
        stash_reg <= word_in;
        hold_reg <= aop_pkg::HOLD_CLKS;
      end else if (hold_reg != '0) begin
        hold_reg <= hold_reg - 1'b1;
      end
      if (hold_reg == aop_pkg::HOLD_LAST) begin
        word_reg <= stash_reg;
      end else if (take & ~unsent) begin
        word_reg <= word_in;
      end
    end
  end

  // ready: low while a loaded word is unsent, high otherwise
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdy_n_reg <= 1'b1;
    end else if (load_now) begin
      rdy_n_reg <= 1'b0;
    end else if (pulse_go | ((sent_next == aop_pkg::WORD_BITS) & (sent_reg != aop_pkg::WORD_BITS))) begin
      rdy_n_reg <= 1'b1;
    end
  end

  // transmit sequencing for all three modes
  always_comb begin
    st_next = st_reg;
    sent_next = sent_reg;
    sc_next = sc_reg;
    fb_next = fb_reg;
    armed_next = armed_reg | sel_n;
    if (load_now | (hold_reg != '0)) begin
      st_next = aop_pkg::TX_OFF;
      sc_next = '0;
      fb_next = '0;
      if (load_now) begin
        sent_next = '0;
      end
    end else if (!awake) begin
      st_next = st_reg;
    end else if (!en_reg) begin
      st_next = aop_pkg::TX_OFF;
    end else if (is_self) begin
      if (st_reg == aop_pkg::TX_OFF) begin
        if (dig_start & ~sel_n & unsent) begin
          st_next = aop_pkg::TX_ON;
          sc_next = '0;
        end
      end else begin
        sc_next = sc_reg + 1'b1;
        if (sc_reg == '1) begin
          sent_next = sent_reg + 1'b1;
          if ((sent_next == aop_pkg::WORD_BITS) | sel_n | per_end) begin
            st_next = aop_pkg::TX_OFF;
          end
        end
      end
    end else if (is_ext) begin
      st_next = (~sel_n & unsent) ? aop_pkg::TX_ON : aop_pkg::TX_OFF;
      if (busy & ~sel_n & sclk_fall) begin
        sent_next = sent_reg + 1'b1;
        if (sent_next == aop_pkg::WORD_BITS) begin
          st_next = aop_pkg::TX_OFF;
        end
      end
    end else if (is_async) begin
      if (st_reg == aop_pkg::TX_OFF) begin
        if (armed_reg & ~sel_n & sclk_fall & unsent) begin
          st_next = aop_pkg::TX_ON;
          fb_next = '0;
          armed_next = 1'b0;
        end
      end else if (sclk_fall) begin
        fb_next = fb_reg + 1'b1;
        if (fb_reg == aop_pkg::FRAME_LAST) begin
          st_next = aop_pkg::TX_OFF;
          sent_next = sent_reg + aop_pkg::BYTE_BITS;
        end
      end
    end else begin
      st_next = aop_pkg::TX_OFF;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= aop_pkg::TX_OFF;
      sent_reg <= '0;
      sc_reg <= '0;
      fb_reg <= '0;
      armed_reg <= 1'b1;
    end else begin
      st_reg <= st_next;
      sent_reg <= sent_next;
      sc_reg <= sc_next;
      fb_reg <= fb_next;
      armed_reg <= armed_next;
    end
  end

  // next serial bit; uses next-state so data and clock fall on one edge
  always_comb begin
    ser_next = 1'b1;
    cur_byte = sent_reg[aop_pkg::BYTE_SEL] ? word_reg[7:0] : word_reg[15:8];
    if (is_async) begin
      if (fb_next == '0) begin
        ser_next = 1'b0;
      end else if (fb_next <= aop_pkg::FRAME_DATA_LAST) begin
        ser_next = cur_byte[3'(fb_next - 4'h1)];
      end
    end else begin
      ser_next = word_reg[~sent_next[3:0]];
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      serial_out <= 1'b1;
      serial_oe_out <= 1'b0;
      sclk_out <= 1'b0;
      sclk_oe_out <= 1'b0;
      word_ready_n_out <= 1'b1;
    end else begin
      serial_out <= ser_next;
      serial_oe_out <= awake & en_reg & (st_next == aop_pkg::TX_ON);
      sclk_out <= sc_next[aop_pkg::SC_W-1];
      sclk_oe_out <= awake & en_reg & is_self & (st_next == aop_pkg::TX_ON);
      word_ready_n_out <= rdy_n_reg | cal_busy_in | ~settled_reg;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  sleep_float_a: assert property (!awake |=> !serial_oe_out && !sclk_oe_out)
    else $error("port drives a pin in standby");
  mode_clk_a: assert property (sclk_oe_out |-> $past(is_self))
    else $error("shift clock driven outside self-clocked mode");
  phase_wrap_a: assert property (awake && ph_reg == '1 |=> ph_reg == '0)
    else $error("sampling interval not 1024 clocks");
  dig_only_a: assert property (is_self && busy |-> ph_reg[aop_pkg::PH_W-1])
    else $error("self-clocked send outside computation period");
  done_float_a: assert property ($rose(sent_reg == aop_pkg::WORD_BITS) |-> !serial_oe_out ##1 word_ready_n_out)
    else $error("no float or ready after last bit");
  sclk_fall_a: assert property (is_self && $past(serial_oe_out) && serial_oe_out && $changed(serial_out)
    |-> $fell(sclk_out))
    else $error("self-clocked data changed off falling clock");
  hold_pulse_a: assert property (hold_reg == aop_pkg::HOLD_CLKS |-> rdy_n_reg [*4] ##1 !rdy_n_reg)
    else $error("ready pulse not four clocks");
  ext_keep_a: assert property (is_ext && !sel_n && busy && word_valid_in |=> $stable(word_reg))
    else $error("word replaced during external transfer");
  ext_float_a: assert property (awake && is_ext && sel_n |=> !serial_oe_out)
    else $error("data driven with select high");
  start_bit_a: assert property (is_async && $rose(serial_oe_out) |-> !serial_out)
    else $error("byte frame without low start bit");
  cal_ready_a: assert property (cal_busy_in |=> word_ready_n_out)
    else $error("ready low during calibration");

  self_done_c: cover property (is_self && $rose(sent_reg == aop_pkg::WORD_BITS));
  ext_resume_c: cover property (is_ext && busy ##1 !busy && sent_reg != '0 ##[1:200] busy);
  async_two_c: cover property (is_async && sent_reg == aop_pkg::BYTE_BITS ##[1:1000] sent_reg == aop_pkg::WORD_BITS);
endmodule : aop_serial_port
`default_nettype wire

// ===== verilog/aop_pkg.sv
// shared constants and types for the converter serial output port
package aop_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 32;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam int BYTE_SEL = 3;
  // sampling interval: 16 periods of 64 master clocks
  localparam int PH_W = 10;
  localparam int SUB_W = 6;
  localparam int SC_W = 2;
  localparam logic [2:0] HOLD_CLKS = 3'h4;
  localparam logic [2:0] HOLD_LAST = 3'h1;
  localparam logic [3:0] FRAME_DATA_LAST = 4'h8;
  localparam logic [3:0] FRAME_LAST = 4'ha;
  localparam int SETTLE_CYCLES = 507904;
  localparam int SET_W = 19;
  // strap codes: high, ground, negative rail
  localparam logic [1:0] MODE_EXT = 2'h0;
  localparam logic [1:0] MODE_SELF = 2'h1;
  localparam logic [1:0] MODE_ASYNC = 2'h2;
  // pin order: mode[1:0], sleep_n, sclk, select_n
  localparam int PIN_W = 5;
  localparam logic [4:0] PIN_RST = 5'h07;
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_WORD = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  typedef enum logic {TX_OFF, TX_ON} aop_tx_type;
endpackage : aop_pkg

// ===== bench/aop_host_model.sv
// host serial port model: shift clock source and bit capture
`timescale 1ns/1ps
`default_nettype none
module aop_host_model (
  // pins
  input wire logic line_in,
  input wire logic sclk_pin_in,
  input wire logic sclk_dev_oe_in,
  output logic sclk_out
);
  logic [15:0] got;
  initial sclk_out = 1'b1;
  // device clock: bit taken on the rising edge
  always @(posedge sclk_pin_in) if (sclk_dev_oe_in) got = {got[14:0], line_in};
  // clock idles high outside frames; bit taken just before each fall
  task automatic shift(input int n);
    #7;
    repeat (n) begin
      #160 got = {got[14:0], line_in};
      sclk_out = 1'b0;
      #160 sclk_out = 1'b1;
    end
  endtask : shift
endmodule : aop_host_model
`default_nettype wire

// ===== bench/test_adc_serial_output_port.sv
// self-checking bench for the converter serial output port
`timescale 1ns/1ps
`default_nettype none
module test_adc_serial_output_port;
  logic clk_in, arst_n_in, psel, penable, pwrite, valid, cal_busy, sleep_n, select_n;
  logic pready, pslverr, err, sclk_dev, sclk_oe, ser, ser_oe, rdy_n, host_sclk, line, sclk_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] word;
  logic [1:0] mode;
  int errors = 0;
  int cmp_count = 0;
  // line has a pull-up, so a floated output reads high
  assign line = ser_oe ? ser : 1'b1;
  assign sclk_pin = sclk_oe ? sclk_dev : host_sclk;
  aop_serial_port #(.SETTLE_CYCLES(64)) DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .word_in(word), .word_valid_in(valid), .cal_busy_in(cal_busy), .mode_strap_in(mode),
    .sleep_n_in(sleep_n), .select_n_in(select_n), .sclk_in(sclk_pin), .sclk_out(sclk_dev),
    .sclk_oe_out(sclk_oe), .serial_out(ser), .serial_oe_out(ser_oe), .word_ready_n_out(rdy_n));
  aop_host_model host (.line_in(line), .sclk_pin_in(sclk_pin), .sclk_dev_oe_in(sclk_oe),
    .sclk_out(host_sclk));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic timeout(input string what);
    errors++;
    $display("BAD %s expected done seen timeout", what);
    give_verdict();
  endtask : timeout
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (pready === 1'b1) break;
    end
    if (n == 20) timeout("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_in);
  endtask : apb
  task automatic load(input logic [15:0] w);
    word <= w;
    valid <= 1'b1;
    @(posedge clk_in);
    valid <= 1'b0;
  endtask : load
  task automatic wait_rdy(input logic v, input int bound);
    int n;
    cmp_count++;
    for (n = 0; n < bound; n++) begin
      @(negedge clk_in);
      if (rdy_n === v) break;
    end
    if (n == bound) timeout("ready");
    @(posedge clk_in);
  endtask : wait_rdy
  // one byte frame: start low, data lsb first, two stops high
  task automatic frame_chk(input logic [7:0] b);
    logic [10:0] f;
    f = 11'h003;
    for (int i = 0; i < 8; i++) f[9-i] = b[i];
    select_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    host.shift(12);
    @(posedge clk_in);
    check("frame", 32'(f), 32'(host.got[10:0]));
    select_n <= 1'b1;
    repeat (6) @(posedge clk_in);
  endtask : frame_chk
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    {arst_n_in, psel, penable, pwrite, valid, cal_busy} = 6'h00;
    {sleep_n, select_n, paddr, pwdata, word, mode} = {2'h3, 8'h00, 32'h0, 16'h0, 2'h0};
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    apb(1'b0, aop_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", 32'h1, rd);
    apb(1'b1, aop_pkg::REG_CTRL, 32'h0);
    apb(1'b0, aop_pkg::REG_CTRL, 32'h0);
    check("ctrl write", 32'h0, rd);
    apb(1'b1, aop_pkg::REG_CTRL, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped err", 32'h1, 32'(err));
    $display("test registers done");
    load(16'ha5c3);
    wait_rdy(1'b0, 10);
    select_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    host.shift(4);
    @(posedge clk_in);
    load(16'h1234);
    host.shift(4);
    @(posedge clk_in);
    select_n <= 1'b1;
    repeat (6) @(negedge clk_in);
    check("float on deselect", 32'h0, 32'(ser_oe));
    @(posedge clk_in);
    select_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    host.shift(8);
    @(posedge clk_in);
    check("ext word", 32'ha5c3, 32'(host.got));
    wait_rdy(1'b1, 20);
    check("ext float", 32'h0, 32'(ser_oe));
    select_n <= 1'b1;
    $display("test external done");
    load(16'h5a0f);
    wait_rdy(1'b0, 10);
    load(16'h0ff0);
    repeat (4) @(negedge clk_in);
    check("ready pulse", 32'h1, 32'(rdy_n));
    repeat (3) @(negedge clk_in);
    check("ready reload", 32'h0, 32'(rdy_n));
    @(posedge clk_in);
    apb(1'b0, aop_pkg::REG_WORD, 32'h0);
    check("kept word", 32'h0ff0, rd);
    cal_busy <= 1'b1;
    repeat (3) @(negedge clk_in);
    check("cal ready", 32'h1, 32'(rdy_n));
    @(posedge clk_in);
    cal_busy <= 1'b0;
    select_n <= 1'b0;
    repeat (6) @(posedge clk_in);
    sleep_n <= 1'b0;
    repeat (6) @(negedge clk_in);
    check("sleep float", 32'h0, 32'(ser_oe));
    @(posedge clk_in);
    sleep_n <= 1'b1;
    select_n <= 1'b1;
    repeat (30) @(negedge clk_in);
    check("settle ready", 32'h1, 32'(rdy_n));
    @(posedge clk_in);
    $display("test standby done");
    mode <= aop_pkg::MODE_ASYNC;
    repeat (80) @(posedge clk_in);
    load(16'hc35a);
    repeat (8) @(posedge clk_in);
    frame_chk(8'hc3);
    frame_chk(8'h5a);
    wait_rdy(1'b1, 20);
    load(16'h3cc3);
    repeat (8) @(posedge clk_in);
    frame_chk(8'h3c);
    load(16'h9966);
    repeat (8) @(posedge clk_in);
    frame_chk(8'h99);
    $display("test byte mode done");
    mode <= aop_pkg::MODE_SELF;
    repeat (4) @(posedge clk_in);
    load(16'h6e91);
    repeat (8) @(posedge clk_in);
    select_n <= 1'b0;
    wait_rdy(1'b1, 1300);
    check("self word", 32'h6e91, 32'(host.got));
    check("self float", 32'h0, 32'({ser_oe, sclk_oe}));
    $display("test self clocked done");
    give_verdict();
  end
endmodule : test_adc_serial_output_port
`default_nettype wire
